// file: shared/awc_consts.svh
// constants for the window compare converter control block
// Operation
// - each monitored channel holds a writable eight-bit lower window bound
// - each monitored channel holds a writable eight-bit upper window bound
// - high flag sets when result is at or above upper bound
// - low flag sets when result is strictly below lower bound
// - clearing a request flag in interrupt control zeroes all compare flags
// - bit three of compare result register always reads one
// - three-bit divide code selects converter clock division factor
// - any control register write aborts conversion and restarts autoscan
// - autoscan starts at selected channel and ends after channel seven
// - pin trigger enable starts a sequence on external pin edge
// - timer trigger enable starts a sequence; both sources are ORed
// - accepted trigger sets go; single mode clears go at sequence end
// - bias off idles all converter logic; bias on enables it
// - repeat select zero runs one sequence, one repeats continuously
// - writing go one starts, zero stops; single mode clears go
// - done flag sets per group; software clears; software set requests
// - alarm flag sets on window exit; software clears; software set requests
// - each request passes only when its mask bit is one
// - alarm is served before done; done stays pending
// - vector word select is zero for alarm, one for done
// - finished channel overwrites its data register with the new result
`ifndef AWC_CONSTS_SVH
`define AWC_CONSTS_SVH
`define AWC_ADDR_W 10
`define AWC_PAGE_HI 4'hf
`define AWC_IDX_THR_BIT 3
`define AWC_IDX_LT6 8'hf8
`define AWC_IDX_LT7 8'hf9
`define AWC_IDX_UT6 8'hfa
`define AWC_IDX_UT7 8'hfb
`define AWC_IDX_CRR 8'hfc
`define AWC_IDX_CTRL 8'hfd
`define AWC_IDX_ICR 8'hfe
`define AWC_IDX_IVR 8'hff
`define AWC_CRR_DIV_RST 3'h7
`define AWC_ICR_RST 8'h0f
`define AWC_CTRL_RST 8'h00
`define AWC_VWS_RST 1'b1
`define AWC_IVR_VEC_LSB 2
`define AWC_FDF_0 5'h10
`define AWC_FDF_1 5'h0e
`define AWC_FDF_2 5'h0c
`define AWC_FDF_3 5'h0a
`define AWC_FDF_4 5'h08
`define AWC_FDF_5 5'h06
`define AWC_FDF_6 5'h04
`define AWC_FDF_7 5'h01
`define AWC_CONV_LAST 8'h89
`define AWC_LAST_CH 3'h7
`define AWC_MON_CH0 3'h6
`define AWC_RESP_OKAY 2'h0
`define AWC_RESP_SLVERR 2'h2
`endif

// file: shared/awc_pkg.sv
// types for the window compare converter control block
package awc_pkg;
  typedef struct packed {
    logic [2:0] first_channel_select;
    logic pin_trigger_enable;
    logic timer_trigger_enable;
    logic bias_on;
    logic repeat_select;
    logic go_flag;
  } awc_ctrl_type;
  typedef struct packed {
    logic conversion_done_flag;
    logic window_alarm_flag;
    logic done_irq_mask;
    logic alarm_irq_mask;
    logic spare;
    logic [2:0] priority_level;
  } awc_icr_type;
  typedef enum logic [1:0] {
    AWC_IDLE = 2'b01,
    AWC_CONV = 2'b10
  } awc_seq_type;
endpackage

// file: core/awc_top.sv
// converter control: autoscan sequencer, window compare, flags, axi4-lite registers
`include "awc_consts.svh"
module awc_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [9:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [9:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_external_trigger_pin,
  input wire logic i_timer_event,
  input wire logic [7:0] i_result,
  output logic o_bias_on,
  output logic [2:0] o_convert_channel,
  output logic o_converting,
  output logic o_irq,
  output logic o_vector_word_select
);
  function automatic logic awc_mapped(input logic [7:0] idx);
    awc_mapped = (idx[7:4] == `AWC_PAGE_HI);
  endfunction

  function automatic logic [4:0] awc_fdf(input logic [2:0] code);
    case (code)
      3'h0: awc_fdf = `AWC_FDF_0;
      3'h1: awc_fdf = `AWC_FDF_1;
      3'h2: awc_fdf = `AWC_FDF_2;
      3'h3: awc_fdf = `AWC_FDF_3;
      3'h4: awc_fdf = `AWC_FDF_4;
      3'h5: awc_fdf = `AWC_FDF_5;
      3'h6: awc_fdf = `AWC_FDF_6;
      default: awc_fdf = `AWC_FDF_7;
    endcase
  endfunction

  awc_pkg::awc_ctrl_type ctrl;
  awc_pkg::awc_icr_type icr;
  awc_pkg::awc_seq_type seq;
  logic [7:0] data_reg [0:7];
  logic [7:0] thr_low [0:1];
  logic [7:0] thr_high [0:1];
  logic [3:0] cmp_flags, next_cmp_flags;
  logic [2:0] div_code, chan;
  logic [5:0] vector_base;
  logic [9:0] aw_addr;
  logic [7:0] w_byte, wr_idx, rd_idx, rd_byte, conv_cnt;
  logic [4:0] div_cnt, fdf;
  logic [1:0] hit_hi, hit_lo;
  logic aw_got, w_got, w_lane, wr_fire, wr_en;
  logic clr_wr, crr_wr, icr_wr, icr_clear;
  logic pin_meta, pin_sync, pin_prev, pin_fall;
  logic trig, running, tick, conv_end, group_end;

  // axi4-lite write path: address and data taken in either order
  assign wr_fire = aw_got && w_got && !o_bvalid;
  assign wr_idx = aw_addr[9:2];
  assign wr_en = wr_fire && w_lane && awc_mapped(wr_idx);
  assign clr_wr = wr_en && (wr_idx == `AWC_IDX_CTRL);
  assign crr_wr = wr_en && (wr_idx == `AWC_IDX_CRR);
  assign icr_wr = wr_en && (wr_idx == `AWC_IDX_ICR);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_got <= 1'b0;
      o_awready <= 1'b0;
      aw_addr <= 10'h000;
    end else if (i_awvalid && o_awready) begin
      aw_got <= 1'b1;
      o_awready <= 1'b0;
      aw_addr <= i_awaddr;
    end else if (wr_fire) begin
      aw_got <= 1'b0;
    end else if (!aw_got) begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      w_got <= 1'b0;
      o_wready <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_got <= 1'b1;
      o_wready <= 1'b0;
      w_byte <= i_wdata[7:0];
      w_lane <= i_wstrb[0];
    end else if (wr_fire) begin
      w_got <= 1'b0;
    end else if (!w_got) begin
      o_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp <= `AWC_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= awc_mapped(wr_idx) ? `AWC_RESP_OKAY : `AWC_RESP_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // read path; reads have no side effects
  assign rd_idx = i_araddr[9:2];
  always_comb begin
    rd_byte = 8'h00;
    if (awc_mapped(rd_idx) && !rd_idx[`AWC_IDX_THR_BIT]) begin
      rd_byte = data_reg[rd_idx[2:0]];
    end else begin
      case (rd_idx)
        `AWC_IDX_LT6: rd_byte = thr_low[0];
        `AWC_IDX_LT7: rd_byte = thr_low[1];
        `AWC_IDX_UT6: rd_byte = thr_high[0];
        `AWC_IDX_UT7: rd_byte = thr_high[1];
        `AWC_IDX_CRR: rd_byte = {cmp_flags, 1'b1, div_code};
        `AWC_IDX_CTRL: rd_byte = ctrl;
        `AWC_IDX_ICR: rd_byte = icr;
        `AWC_IDX_IVR: rd_byte = {vector_base, o_vector_word_select, 1'b0};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `AWC_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= {24'h00_0000, rd_byte};
      o_rresp <= awc_mapped(rd_idx) ? `AWC_RESP_OKAY : `AWC_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end else if (!o_rvalid) begin
      o_arready <= 1'b1;
    end
  end

  // threshold, crr divide code and vector registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      thr_low[0] <= 8'h00;
      thr_low[1] <= 8'h00;
      thr_high[0] <= 8'h00;
      thr_high[1] <= 8'h00;
      div_code <= `AWC_CRR_DIV_RST;
      vector_base <= 6'h00;
    end else if (wr_en) begin
      if (wr_idx == `AWC_IDX_LT6) thr_low[0] <= w_byte;
      if (wr_idx == `AWC_IDX_LT7) thr_low[1] <= w_byte;
      if (wr_idx == `AWC_IDX_UT6) thr_high[0] <= w_byte;
      if (wr_idx == `AWC_IDX_UT7) thr_high[1] <= w_byte;
      if (crr_wr) div_code <= w_byte[2:0];
      if (wr_idx == `AWC_IDX_IVR) vector_base <= w_byte[7:`AWC_IVR_VEC_LSB];
    end
  end

  // trigger pin synchroniser; a low pulse is detected by its falling edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
    end else begin
      pin_meta <= i_external_trigger_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  assign pin_fall = pin_prev && !pin_sync;

  assign trig = (pin_fall && ctrl.pin_trigger_enable) || (i_timer_event && ctrl.timer_trigger_enable);
  assign running = ctrl.go_flag && ctrl.bias_on;

  // control register; a write replaces go, so a trigger in that cycle is lost
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= `AWC_CTRL_RST;
    end else if (clr_wr) begin
      ctrl <= w_byte;
    end else if (trig && !ctrl.go_flag) begin
      ctrl.go_flag <= 1'b1;
    end else if (group_end && !ctrl.repeat_select) begin
      ctrl.go_flag <= 1'b0;
    end
  end

  // sequencer state; a control write drops to idle, which aborts the scan
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seq <= awc_pkg::AWC_IDLE;
    end else begin
      case (seq)
        awc_pkg::AWC_IDLE: begin
          if (running && !clr_wr) seq <= awc_pkg::AWC_CONV;
        end
        awc_pkg::AWC_CONV: begin
          if (clr_wr || !running || (group_end && !ctrl.repeat_select)) seq <= awc_pkg::AWC_IDLE;
        end
        default: seq <= awc_pkg::AWC_IDLE;
      endcase
    end
  end

  assign fdf = awc_fdf(div_code);
  assign tick = (seq == awc_pkg::AWC_CONV) && running && (div_cnt == fdf - 5'h01);
  assign conv_end = tick && (conv_cnt == `AWC_CONV_LAST);
  assign group_end = conv_end && (chan == `AWC_LAST_CH);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt <= 5'h00;
      conv_cnt <= 8'h00;
      chan <= 3'h0;
    end else if (seq != awc_pkg::AWC_CONV || clr_wr) begin
      div_cnt <= 5'h00;
      conv_cnt <= 8'h00;
      chan <= clr_wr ? w_byte[7:5] : ctrl.first_channel_select;
    end else if (running) begin
      div_cnt <= tick ? 5'h00 : div_cnt + 5'h01;
      if (conv_end) begin
        conv_cnt <= 8'h00;
        // autoscan wraps to first channel after seven
        chan <= (chan == `AWC_LAST_CH) ? ctrl.first_channel_select : chan + 3'h1;
      end else if (tick) begin
        conv_cnt <= conv_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < 8; k++) data_reg[k] <= 8'h00;
    end else if (conv_end) begin
      data_reg[chan] <= i_result;
    end
  end

  for (genvar gi = 0; gi < 2; gi++) begin : g_mon
    assign hit_hi[gi] = conv_end && (chan == `AWC_MON_CH0 + 3'(gi)) && (i_result >= thr_high[gi]);
    assign hit_lo[gi] = conv_end && (chan == `AWC_MON_CH0 + 3'(gi)) && (i_result < thr_low[gi]);
  end

  assign icr_clear = icr_wr && ((icr.conversion_done_flag && !w_byte[7]) || (icr.window_alarm_flag && !w_byte[6]));

  // new hits win over a software or icr-driven clear in the same cycle
  always_comb begin
    next_cmp_flags = cmp_flags;
    if (icr_clear) begin
      next_cmp_flags = 4'h0;
    end else if (crr_wr) begin
      next_cmp_flags = w_byte[7:4];
    end
    next_cmp_flags = next_cmp_flags | {hit_hi[1], hit_hi[0], hit_lo[1], hit_lo[0]};
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_flags <= 4'h0;
    end else begin
      cmp_flags <= next_cmp_flags;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      icr <= `AWC_ICR_RST;
    end else begin
      if (icr_wr) icr <= w_byte;
      if (group_end) icr.conversion_done_flag <= 1'b1;
      if (|{hit_hi, hit_lo}) icr.window_alarm_flag <= 1'b1;
    end
  end

  // request and vector select; alarm checked first so done waits
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
      o_vector_word_select <= `AWC_VWS_RST;
    end else begin
      o_irq <= (icr.conversion_done_flag && icr.done_irq_mask) || (icr.window_alarm_flag && icr.alarm_irq_mask);
      if (icr.window_alarm_flag && icr.alarm_irq_mask) begin
        o_vector_word_select <= 1'b0;
      end else if (icr.conversion_done_flag && icr.done_irq_mask) begin
        o_vector_word_select <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bias_on <= 1'b0;
      o_convert_channel <= 3'h0;
      o_converting <= 1'b0;
    end else begin
      o_bias_on <= ctrl.bias_on;
      o_convert_channel <= chan;
      o_converting <= (seq == awc_pkg::AWC_CONV) && running;
    end
  end

  // helper: cycles between divider ticks
  logic [4:0] gap;
  logic gap_ok;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap <= 5'h00;
      gap_ok <= 1'b0;
    end else if (seq != awc_pkg::AWC_CONV || clr_wr || !running) begin
      gap <= 5'h00;
      gap_ok <= 1'b0;
    end else begin
      gap <= tick ? 5'h01 : gap + 5'h01;
      gap_ok <= gap_ok || tick;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_ch6_high;
    conv_end && chan == `AWC_MON_CH0 && i_result >= thr_high[0];
  endsequence
  sequence s_single_end;
    group_end && !ctrl.repeat_select && !clr_wr;
  endsequence

  a_high_flag_set: assert property (s_ch6_high |=> cmp_flags[2] && icr.window_alarm_flag)
    else $error("ch6 high flag or alarm not set");
  a_low_flag_set: assert property (hit_lo[1] |=> cmp_flags[1] && icr.window_alarm_flag)
    else $error("ch7 low flag or alarm not set");
  a_inside_window: assert property (conv_end && chan == `AWC_MON_CH0 && i_result >= thr_low[0]
    && i_result < thr_high[0] && !icr_clear && !crr_wr |=> cmp_flags == $past(cmp_flags))
    else $error("flags changed for in-window result");
  a_icr_clear_flags: assert property (icr_clear && !(|{hit_hi, hit_lo}) |=> cmp_flags == 4'h0)
    else $error("compare flags not cleared");
  a_crr_bit_three: assert property (i_arvalid && o_arready && rd_idx == `AWC_IDX_CRR |=> o_rvalid && o_rdata[3])
    else $error("crr bit three not one");
  a_div_period: assert property (tick && gap_ok && $stable(div_code) |-> gap == fdf)
    else $error("divider tick spacing wrong");
  a_ctrl_abort: assert property (clr_wr |=> seq == awc_pkg::AWC_IDLE && conv_cnt == 8'h00
    && chan == ctrl.first_channel_select)
    else $error("control write did not abort");
  a_trigger_go: assert property (trig && !ctrl.go_flag && !clr_wr |=> ctrl.go_flag)
    else $error("trigger did not set go");
  a_single_clear: assert property (s_single_end |=> !ctrl.go_flag ##1 !o_converting)
    else $error("single mode did not stop");
  a_data_write: assert property (conv_end |=> data_reg[$past(chan)] == $past(i_result))
    else $error("data register not overwritten");
  a_irq_masked: assert property (!icr.done_irq_mask && !icr.alarm_irq_mask |=> !o_irq)
    else $error("masked request passed");
  a_alarm_first: assert property (icr.window_alarm_flag && icr.alarm_irq_mask |=> !o_vector_word_select && o_irq)
    else $error("alarm not selected first");
endmodule

// file: testbench/awc_far_end.sv
// far side model: timer event source, trigger pin driver and converter result
module awc_far_end (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_fire_timer,
  input wire logic i_fire_pin,
  input wire logic [7:0] i_level,
  output logic o_timer_event,
  output logic o_pin,
  output logic [7:0] o_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] low_cnt;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_timer_event <= 1'b0;
    end else begin
      o_timer_event <= i_fire_timer;
    end
  end
  // low pulse of four clocks, well over one period
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_cnt <= 3'h0;
    end else if (i_fire_pin) begin
      low_cnt <= 3'h4;
    end else if (low_cnt != 3'h0) begin
      low_cnt <= low_cnt - 3'h1;
    end
  end
  // pin idles high so only the pulse start is a falling edge
  assign o_pin = (low_cnt == 3'h0);
  assign o_result = i_level;
endmodule

// file: testbench/awc_top_test.sv
// register-level testbench for the converter control block
`include "awc_consts.svh"
module awc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_nrst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pin, tev, bias, conv, irq, vws, fire_t, fire_p;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] level, result;
  logic [3:0] wstrb;
  logic [2:0] chn;
  int num_errors, n_checks, cycles, conv_len, i;

  awc_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_external_trigger_pin(pin),
    .i_timer_event(tev), .i_result(result), .o_bias_on(bias), .o_convert_channel(chn),
    .o_converting(conv), .o_irq(irq), .o_vector_word_select(vws));
  awc_far_end far (.i_clk(i_clk), .i_nrst(i_nrst), .i_fire_timer(fire_t), .i_fire_pin(fire_p),
    .i_level(level), .o_timer_event(tev), .o_pin(pin), .o_result(result));

  always #50 i_clk = ~i_clk;
  // hang guard: the whole run needs a few thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (conv === 1'b1) conv_len++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    int n;
    n = 0;
    @(posedge i_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n == 0) begin
      @(posedge i_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        n = 1;
      end
    end
    check_bit(awvalid || wvalid, 1'b0, "write channels not taken");
  endtask
  task automatic rdx(input logic [7:0] idx);
    int n;
    n = 0;
    @(posedge i_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n == 0) begin
      @(posedge i_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        n = 1;
      end
    end
    check_bit(arvalid, 1'b0, "read address not taken");
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    rdx(idx);
    check_val(rd, {24'h0, exp}, "register read");
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    rdx(`AWC_IDX_ICR);
    while (rd[7] !== 1'b1 && n < 1000) begin
      rdx(`AWC_IDX_ICR);
      n++;
    end
    check_bit(rd[7], 1'b1, "scan done flag");
  endtask
  task automatic fire(input logic use_pin);
    @(posedge i_clk);
    fire_p <= use_pin;
    fire_t <= !use_pin;
    @(posedge i_clk);
    fire_p <= 1'b0;
    fire_t <= 1'b0;
  endtask

  initial begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h1;
    level = 8'h00;
    fire_t = 1'b0;
    fire_p = 1'b0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    check_bit(vws, 1'b1, "word select at reset");
    rd_chk(`AWC_IDX_CRR, 8'h0f);
    rd_chk(`AWC_IDX_CTRL, 8'h00);
    rd_chk(`AWC_IDX_ICR, 8'h0f);
    rdx(8'h10);
    check_val({30'h0, resp}, {30'h0, `AWC_RESP_SLVERR}, "unmapped read response");
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      wr(8'(8'hf8 + i), (i < 2) ? 8'h40 : 8'hc0);
      rd_chk(8'(8'hf8 + i), (i < 2) ? 8'h40 : 8'hc0);
    end
    wr(`AWC_IDX_CRR, 8'h06);
    rd_chk(`AWC_IDX_CRR, 8'h0e);
    // a write with lane zero disabled must not store
    wstrb <= 4'h0;
    wr(`AWC_IDX_LT6, 8'h11);
    wstrb <= 4'h1;
    rd_chk(`AWC_IDX_LT6, 8'h40);
    $display("test thresholds done");
    // upper bound hit exactly on both channels, divide factor four, single scan from channel six
    level <= 8'hc0;
    conv_len = 0;
    wr(`AWC_IDX_CTRL, 8'hc5);
    @(posedge i_clk);
    check_bit(bias, 1'b1, "bias output");
    wait_done();
    check_bit(conv_len >= 1104 && conv_len <= 1106, 1'b1, "scan length for code 6");
    rd_chk(`AWC_IDX_CRR, 8'hce);
    rd_chk(`AWC_IDX_ICR, 8'hcf);
    rd_chk(`AWC_IDX_CTRL, 8'hc4);
    rd_chk(8'hf6, 8'hc0);
    rd_chk(8'hf7, 8'hc0);
    check_bit(irq, 1'b0, "masked request");
    $display("test upper bound done");
    wr(`AWC_IDX_ICR, 8'hef);
    repeat (3) @(posedge i_clk);
    check_bit(irq, 1'b1, "done request passed");
    check_bit(vws, 1'b1, "word select for done");
    wr(`AWC_IDX_ICR, 8'hff);
    repeat (3) @(posedge i_clk);
    check_bit(vws, 1'b0, "alarm served first");
    wr(`AWC_IDX_ICR, 8'h3f);
    rd_chk(`AWC_IDX_CRR, 8'h0e);
    repeat (3) @(posedge i_clk);
    check_bit(irq, 1'b0, "request gone after clear");
    $display("test requests done");
    // strictly below lower bound on both channels, timer start
    wr(`AWC_IDX_CRR, 8'h07);
    wr(`AWC_IDX_ICR, 8'h0f);
    level <= 8'h3f;
    wr(`AWC_IDX_CTRL, 8'hcc);
    fire(1'b1);
    repeat (6) @(posedge i_clk);
    check_bit(conv, 1'b0, "pin ignored when disabled");
    fire(1'b0);
    repeat (10) @(posedge i_clk);
    check_val({29'h0, chn}, 32'h0000_0006, "channel under conversion");
    wait_done();
    rd_chk(`AWC_IDX_CRR, 8'h3f);
    rd_chk(`AWC_IDX_CTRL, 8'hcc);
    rd_chk(8'hf6, 8'h3f);
    rd_chk(`AWC_IDX_ICR, 8'hcf);
    $display("test timer start done");
    // in-window value started from the pin
    wr(`AWC_IDX_ICR, 8'h0f);
    level <= 8'h80;
    wr(`AWC_IDX_CTRL, 8'hd4);
    fire(1'b0);
    repeat (6) @(posedge i_clk);
    check_bit(conv, 1'b0, "timer ignored when disabled");
    fire(1'b1);
    wait_done();
    rd_chk(`AWC_IDX_CRR, 8'h0f);
    rd_chk(`AWC_IDX_ICR, 8'h8f);
    $display("test pin start done");
    wr(`AWC_IDX_ICR, 8'h0f);
    wr(`AWC_IDX_CTRL, 8'he7);
    wait_done();
    rd_chk(`AWC_IDX_CTRL, 8'he7);
    check_bit(conv, 1'b1, "repeat keeps scanning");
    wr(`AWC_IDX_CTRL, 8'he4);
    repeat (3) @(posedge i_clk);
    check_bit(conv, 1'b0, "write stops scan");
    wr(`AWC_IDX_CTRL, 8'he1);
    repeat (10) @(posedge i_clk);
    check_bit(conv, 1'b0, "no scan without bias");
    check_bit(bias, 1'b0, "bias output off");
    wr(8'h20, 8'h55);
    check_val({30'h0, resp}, {30'h0, `AWC_RESP_SLVERR}, "unmapped write response");
    $display("test continuous and stop done");
    stop_test();
  end
endmodule
